// *** common/srg_params.svh ***
// Register offsets, field positions, reset values and timing for the
// serial port clock generator; included by the design in srg_top only.
// Operation
// - Eight-bit divide field in bits 7..0 resets to one, halving input.
// - Bit clock equals input clock over divide field plus one, 1..256.
// - Odd divide gives equal phases; even 2p, zero included, gives high p+1, low p.
// - Resync off: bit clock free runs, frame pulse every period plus one.
// - Resync on: receive frame pin pulse realigns bit clock phase.
// - Resync on: frame pulse only follows receive frame pin; period ignored.
// - Extend bit and mode bit select aux pin, CPU, rx pin, tx pin.
// - Device reset selects the CPU clock as generator input.
// - Aux pin polarity bit 14 picks rising (0) or falling (1) edge.
// - Transmit polarity bit 1 picks rising (0) or falling (1) edge.
// - Receive polarity bit 0 picks rising (1) or falling (0) edge.
// - Free-run set: both sections keep clocking on breakpoint.
// - Both emulation bits clear: sections stop at once on breakpoint.
// - Soft stop: transmitter finishes word then halts; receiver runs on.
// - Section reset clears its counters and status flags.
// - Device reset: tx data high impedance, bit clock follows slow clock.
// - After device reset sections stay reset until software releases.
// - Section in reset stops; clock pin output still runs; tx data hi-Z.
// - Generator reset drives bit clock and frame low; software avoids misuse.
// - Frame pin of a section in reset stays inactive.
// - Generator release starts clock; frame pulse after programmed cycles.
// - Frame pulse lasts width plus one, repeats every period plus one.
`ifndef SRG_PARAMS_SVH
`define SRG_PARAMS_SVH
// Register indices
`define SRG_CFG_ONE 3'h0
`define SRG_CFG_TWO 3'h1
`define SRG_PIN_CTL 3'h2
`define SRG_PORT_CTL 3'h3
`define SRG_STATUS 3'h4
// Reset values
`define SRG_CFG_ONE_RST 16'h0001
`define SRG_CFG_TWO_RST 16'h2000
`define SRG_PIN_CTL_RST 16'h0000
`define SRG_PORT_CTL_RST 16'h0000
// Field positions
`define SRG_RESYNC_BIT 15
`define SRG_AUX_POL_BIT 14
`define SRG_CLK_SEL_BIT 13
`define SRG_EXT_SEL_BIT 7
`define SRG_TX_POL_BIT 1
`define SRG_RX_POL_BIT 0
`define SRG_RX_CLK_OUT_BIT 8
`define SRG_TX_CLK_OUT_BIT 9
`define SRG_RX_FS_OUT_BIT 10
`define SRG_TX_FS_OUT_BIT 11
`define SRG_RX_RST_BIT 0
`define SRG_TX_RST_BIT 1
`define SRG_GEN_RST_BIT 6
`define SRG_FRM_RST_BIT 7
`define SRG_SOFT_BIT 8
`define SRG_FREE_BIT 9
`endif

// *** common/srg_pkg.sv ***
// Types for the serial port clock generator.
// Assumes srg_params.svh sits on the include path.
package srg_pkg;
   // Generator input source, {extend bit, mode bit}
   typedef enum logic [1:0] {
      SRC_AUX = 2'h0,
      SRC_CPU = 2'h1,
      SRC_RX = 2'h2,
      SRC_TX = 2'h3
   } srg_src_t;
   // Emulation stop state of a section, one-hot
   typedef enum logic [1:0] {
      RUN_ON = 2'h1,
      RUN_HALT = 2'h2
   } srg_run_t;
   // Software-visible registers
   typedef struct packed {
      logic [15:0] cfg_one;
      logic [15:0] cfg_two;
      logic [15:0] pin_ctl;
      logic [15:0] port_ctl;
   } srg_regs_t;
   // Pin group driven toward the outside
   typedef struct packed {
      logic rx_clk_o;
      logic rx_clk_oe_n;
      logic tx_clk_o;
      logic tx_clk_oe_n;
      logic rx_fs_o;
      logic rx_fs_oe_n;
      logic tx_fs_o;
      logic tx_fs_oe_n;
      logic tx_data_o;
      logic tx_data_oe_n;
   } srg_pins_t;
   // Whole state of the block
   typedef struct packed {
      srg_regs_t regs;
      logic [15:0] rd_data;
      logic [7:0] pos;
      logic bclk;
      logic frame;
      logic [11:0] per_cnt;
      logic [7:0] wid_cnt;
      logic fs_pend;
      logic aux_q;
      logic rxc_q;
      logic txc_q;
      logic rxf_q;
      logic lsp_q;
      logic post_rst;
      srg_run_t tx_run;
      srg_run_t rx_run;
      srg_pins_t pins;
      logic tx_clk_en;
      logic rx_clk_en;
      logic tx_clear;
      logic rx_clear;
   } srg_state_t;
endpackage

// *** hw/srg_top.sv ***
// Bit clock and frame pulse generator with section reset and
// breakpoint stop control for a buffered serial port.
// Assumes all pin inputs are synchronous to core_clk.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "srg_params.svh"
module srg_top
   import srg_pkg::*;
(
   // Clock and device reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Clock and frame pins, inputs
   input wire logic aux_clock_pin,
   input wire logic rx_clock_pin_i,
   input wire logic tx_clock_pin_i,
   input wire logic rx_frame_pin_i,
   input wire logic low_speed_periph_clock,
   // Clock and frame pins, outputs
   output logic rx_clock_pin_o,
   output logic rx_clock_pin_oe_n,
   output logic tx_clock_pin_o,
   output logic tx_clock_pin_oe_n,
   output logic rx_frame_pin_o,
   output logic rx_frame_pin_oe_n,
   output logic tx_frame_pin_o,
   output logic tx_frame_pin_oe_n,
   // Transmit data pin
   input wire logic tx_shift_bit,
   output logic tx_data_pin_o,
   output logic tx_data_pin_oe_n,
   // Debugger and transmitter handshake
   input wire logic debug_halt,
   input wire logic tx_word_done,
   // Section control toward the data path
   output logic gen_bit_clock,
   output logic gen_frame_pulse,
   output logic tx_clock_enable,
   output logic rx_clock_enable,
   output logic tx_section_clear,
   output logic rx_section_clear
);

   // ----------------------------------------
   // State and decoded fields
   // ----------------------------------------
   srg_state_t s;
   srg_state_t next_s;
   logic [7:0] div;
   logic [7:0] width;
   logic [11:0] period;
   logic [7:0] high_len;
   logic resync_enable;
   srg_src_t src;
   logic tick;
   logic fs_edge;
   logic bclk_start;
   logic gen_run;
   logic frame_run;
   logic tx_rst_n;
   logic rx_rst_n;
   logic soft_stop;
   logic free_run;

   // Field decode from the registers
   always_comb begin
      div = s.regs.cfg_one[7:0];
      width = s.regs.cfg_one[15:8];
      period = s.regs.cfg_two[11:0];
      resync_enable = s.regs.cfg_two[`SRG_RESYNC_BIT];
      src = srg_src_t'({s.regs.pin_ctl[`SRG_EXT_SEL_BIT],
                        s.regs.cfg_two[`SRG_CLK_SEL_BIT]});
      gen_run = s.regs.port_ctl[`SRG_GEN_RST_BIT];
      frame_run = s.regs.port_ctl[`SRG_FRM_RST_BIT];
      tx_rst_n = s.regs.port_ctl[`SRG_TX_RST_BIT];
      rx_rst_n = s.regs.port_ctl[`SRG_RX_RST_BIT];
      soft_stop = s.regs.port_ctl[`SRG_SOFT_BIT];
      free_run = s.regs.port_ctl[`SRG_FREE_BIT];
      // High phase is ceil((div+1)/2) input cycles
      high_len = {1'b0, div[7:1]} + 8'h01;
   end

   // ----------------------------------------
   // Input clock edge selection
   // ----------------------------------------
   // One tick per generating edge of the chosen source
   always_comb begin
      case (src)
         SRC_AUX: begin
            if (s.regs.cfg_two[`SRG_AUX_POL_BIT]) begin
               tick = s.aux_q & ~aux_clock_pin;
            end else begin
               tick = ~s.aux_q & aux_clock_pin;
            end
         end
         SRC_CPU: begin
            tick = 1'b1;
         end
         SRC_RX: begin
            if (s.regs.pin_ctl[`SRG_RX_POL_BIT]) begin
               tick = ~s.rxc_q & rx_clock_pin_i;
            end else begin
               tick = s.rxc_q & ~rx_clock_pin_i;
            end
         end
         SRC_TX: begin
            if (s.regs.pin_ctl[`SRG_TX_POL_BIT]) begin
               tick = s.txc_q & ~tx_clock_pin_i;
            end else begin
               tick = ~s.txc_q & tx_clock_pin_i;
            end
         end
         default: begin
            tick = 1'b0;
         end
      endcase
      fs_edge = ~s.rxf_q & rx_frame_pin_i;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_s = s;
      bclk_start = 1'b0;
      next_s.aux_q = aux_clock_pin;
      next_s.rxc_q = rx_clock_pin_i;
      next_s.txc_q = tx_clock_pin_i;
      next_s.rxf_q = rx_frame_pin_i;
      next_s.lsp_q = low_speed_periph_clock;

      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            `SRG_CFG_ONE: next_s.regs.cfg_one = reg_wdata;
            `SRG_CFG_TWO: next_s.regs.cfg_two = reg_wdata;
            `SRG_PIN_CTL: next_s.regs.pin_ctl = reg_wdata;
            `SRG_PORT_CTL: next_s.regs.port_ctl = reg_wdata;
            default: ;
         endcase
      end

      // Register reads, data stand one cycle later
      next_s.rd_data = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            `SRG_CFG_ONE: next_s.rd_data = s.regs.cfg_one;
            `SRG_CFG_TWO: next_s.rd_data = s.regs.cfg_two;
            `SRG_PIN_CTL: next_s.rd_data = s.regs.pin_ctl;
            `SRG_PORT_CTL: next_s.rd_data = s.regs.port_ctl;
            `SRG_STATUS: next_s.rd_data = {9'h000, s.post_rst,
               s.rx_run == RUN_HALT, s.tx_run == RUN_HALT,
               s.rx_clk_en, s.tx_clk_en, s.frame, s.bclk};
            default: next_s.rd_data = 16'h0000;
         endcase
      end

      // Frame pin edge held until the next bit clock start
      if (fs_edge) begin
         next_s.fs_pend = 1'b1;
      end

      // Divider and frame counters
      if (!gen_run) begin
         next_s.pos = 8'h00;
         next_s.bclk = 1'b0;
         next_s.frame = 1'b0;
         next_s.per_cnt = period;
         next_s.wid_cnt = 8'h00;
         next_s.fs_pend = 1'b0;
      end else if (tick) begin
         next_s.post_rst = 1'b0;
         if (resync_enable && (s.fs_pend || fs_edge)) begin
            next_s.pos = 8'h00;
         end else if (s.pos >= div) begin
            next_s.pos = 8'h00;
         end else begin
            next_s.pos = s.pos + 8'h01;
         end
         next_s.bclk = next_s.pos < high_len;
         bclk_start = next_s.pos == 8'h00;
         if (bclk_start) begin
            // Width countdown ends a running pulse
            if (s.frame) begin
               if (s.wid_cnt == 8'h00) begin
                  next_s.frame = 1'b0;
               end else begin
                  next_s.wid_cnt = s.wid_cnt - 8'h01;
               end
            end
            if (!frame_run) begin
               next_s.frame = 1'b0;
               next_s.per_cnt = period;
            end else if (resync_enable) begin
               if (s.fs_pend || fs_edge) begin
                  next_s.frame = 1'b1;
                  next_s.wid_cnt = width;
               end
            end else if (s.per_cnt == 12'h000) begin
               next_s.per_cnt = period;
               next_s.frame = 1'b1;
               next_s.wid_cnt = width;
            end else begin
               next_s.per_cnt = s.per_cnt - 12'h001;
            end
            next_s.fs_pend = 1'b0;
         end
      end

      // Breakpoint stop of the transmitter
      if (!tx_rst_n || !debug_halt || free_run) begin
         next_s.tx_run = RUN_ON;
      end else if (!soft_stop || tx_word_done) begin
         next_s.tx_run = RUN_HALT;
      end
      // Breakpoint stop of the receiver, soft stop leaves it running
      if (!rx_rst_n || !debug_halt || free_run || soft_stop) begin
         next_s.rx_run = RUN_ON;
      end else begin
         next_s.rx_run = RUN_HALT;
      end
      next_s.tx_clk_en = tx_rst_n && next_s.tx_run == RUN_ON;
      next_s.rx_clk_en = rx_rst_n && next_s.rx_run == RUN_ON;
      next_s.tx_clear = !tx_rst_n;
      next_s.rx_clear = !rx_rst_n;

      // Pin drivers, output enables are active low
      next_s.pins.rx_clk_o = next_s.bclk;
      next_s.pins.rx_clk_oe_n = !(s.regs.pin_ctl[`SRG_RX_CLK_OUT_BIT]
         && gen_run);
      next_s.pins.tx_clk_o = next_s.bclk;
      next_s.pins.tx_clk_oe_n = !(s.regs.pin_ctl[`SRG_TX_CLK_OUT_BIT]
         && gen_run);
      next_s.pins.rx_fs_o = next_s.frame && rx_rst_n;
      next_s.pins.rx_fs_oe_n = !s.regs.pin_ctl[`SRG_RX_FS_OUT_BIT];
      next_s.pins.tx_fs_o = next_s.frame && tx_rst_n;
      next_s.pins.tx_fs_oe_n = !s.regs.pin_ctl[`SRG_TX_FS_OUT_BIT];
      next_s.pins.tx_data_o = tx_shift_bit;
      next_s.pins.tx_data_oe_n = !(tx_rst_n && next_s.tx_clk_en);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Device reset puts every section in reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.regs.cfg_one <= `SRG_CFG_ONE_RST;
         s.regs.cfg_two <= `SRG_CFG_TWO_RST;
         s.regs.pin_ctl <= `SRG_PIN_CTL_RST;
         s.regs.port_ctl <= `SRG_PORT_CTL_RST;
         s.per_cnt <= 12'h000;
         s.post_rst <= 1'b1;
         s.tx_run <= RUN_ON;
         s.rx_run <= RUN_ON;
         s.tx_clear <= 1'b1;
         s.rx_clear <= 1'b1;
         s.pins.rx_clk_oe_n <= 1'b1;
         s.pins.tx_clk_oe_n <= 1'b1;
         s.pins.rx_fs_oe_n <= 1'b1;
         s.pins.tx_fs_oe_n <= 1'b1;
         s.pins.tx_data_oe_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Slow clock stands in for the bit clock until first release
   always_comb begin
      reg_rdata = s.rd_data;
      gen_bit_clock = s.post_rst ? s.lsp_q : s.bclk;
      gen_frame_pulse = s.frame;
      rx_clock_pin_o = s.pins.rx_clk_o;
      rx_clock_pin_oe_n = s.pins.rx_clk_oe_n;
      tx_clock_pin_o = s.pins.tx_clk_o;
      tx_clock_pin_oe_n = s.pins.tx_clk_oe_n;
      rx_frame_pin_o = s.pins.rx_fs_o;
      rx_frame_pin_oe_n = s.pins.rx_fs_oe_n;
      tx_frame_pin_o = s.pins.tx_fs_o;
      tx_frame_pin_oe_n = s.pins.tx_fs_oe_n;
      tx_data_pin_o = s.pins.tx_data_o;
      tx_data_pin_oe_n = s.pins.tx_data_oe_n;
      tx_clock_enable = s.tx_clk_en;
      rx_clock_enable = s.rx_clk_en;
      tx_section_clear = s.tx_clear;
      rx_section_clear = s.rx_clear;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   gen_reset_low_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      !gen_run |=> !s.bclk && !s.frame)
   else $error("bit clock or frame high with generator in reset");

   divide_wrap_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      gen_run && tick && !resync_enable && s.pos >= div |=> s.pos == 8'h00)
   else $error("divider failed to wrap at divide value");

   high_phase_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      gen_run && tick |=> s.bclk == (s.pos < high_len))
   else $error("bit clock phase does not match counter");

   tx_data_hiz_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      !tx_rst_n ##1 !tx_rst_n |-> tx_data_pin_oe_n)
   else $error("transmit data driven while section in reset");

   frame_pin_idle_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      !rx_rst_n ##1 !rx_rst_n |-> !rx_frame_pin_o)
   else $error("receive frame pin active during section reset");

   immediate_stop_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      debug_halt && !free_run && !soft_stop && tx_rst_n
      |=> !tx_clock_enable)
   else $error("transmitter kept running in immediate stop mode");

   free_run_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      free_run && rx_rst_n |=> rx_clock_enable)
   else $error("receiver stopped in free run mode");

   soft_rx_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      soft_stop && !free_run && rx_rst_n && debug_halt |=> rx_clock_enable)
   else $error("receiver stopped in soft stop mode");

   frame_start_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      gen_run && frame_run && tick && !resync_enable && s.pos >= div
      && s.per_cnt == 12'h000 |=> s.frame && s.wid_cnt == width)
   else $error("frame pulse did not start at period end");

   section_clear_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(tx_rst_n) |-> ##1 tx_section_clear)
   else $error("transmit section clear missing after reset bit drop");

   tx_frame_idle_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      !tx_rst_n ##1 !tx_rst_n |-> !tx_frame_pin_o)
   else $error("transmit frame pin active during section reset");

   soft_tx_halt_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      soft_stop && !free_run && debug_halt && tx_rst_n && tx_word_done
      |=> !tx_clock_enable)
   else $error("transmitter kept running after word in soft stop");

   resync_frame_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      gen_run && resync_enable && !s.frame && !s.fs_pend && !fs_edge |=> !s.frame)
   else $error("frame pulse without receive frame pin edge");

   resync_align_a:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      gen_run && tick && resync_enable && (s.fs_pend || fs_edge) |=> s.pos == 8'h00)
   else $error("divider not realigned by receive frame pin");

endmodule // srg_top
`default_nettype wire

// *** testbench/srg_codec_model.sv ***
// Far-side codec model: three pin clocks of different rates, a receive
// frame pulse on request and the slow peripheral clock of the device.
// Assumes the device samples every pin on core_clk.
`timescale 1ns/10ps
`default_nettype none
module srg_codec_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Control from the bench
   input wire logic clk_run,
   input wire logic fs_req,
   // Pins toward the device, pin_clk is {tx, rx, aux}
   output logic [2:0] pin_clk,
   output logic rx_fs,
   output logic lsp_clk
);
   logic [2:0] cnt [3];
   logic [1:0] slow;

   // Slow clock runs free at a quarter of core_clk
   assign lsp_clk = slow[1];

   // Pin clocks stand still while stopped; half periods 5, 6 and 7 cycles
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_clk <= 3'h0;
         cnt <= '{3'h0, 3'h0, 3'h0};
         slow <= 2'h0;
         rx_fs <= 1'h0;
      end else begin
         slow <= slow + 2'h1;
         rx_fs <= fs_req;
         for (int i = 0; i < 3; i++) begin
            if (clk_run && cnt[i] == 3'(4 + i)) begin
               cnt[i] <= 3'h0;
               pin_clk[i] <= ~pin_clk[i];
            end else if (clk_run) begin
               cnt[i] <= cnt[i] + 3'h1;
            end
         end
      end
   end
endmodule // srg_codec_model
`default_nettype wire

// *** testbench/tb_serial_port_sample_rate_gen_reset.sv ***
// Self-checking bench for the bit clock and frame generator.
// Assumes srg_pkg, srg_top and srg_codec_model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      checked++; \
      if ((g) !== (e)) begin \
         error_cnt++; \
         $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
      end \
   end
module tb_serial_port_sample_rate_gen_reset
   import srg_pkg::*;
;
   logic core_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic [2:0] reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic clk_run = 1'h0, fs_req = 1'h0, ext_fs, lsp_clk;
   logic [2:0] ext_clk;
   logic tx_shift_bit = 1'h0, debug_halt = 1'h0, tx_word_done = 1'h0;
   logic rx_clock_pin_o, rx_clock_pin_oe_n, tx_clock_pin_o, tx_clock_pin_oe_n;
   logic rx_frame_pin_o, rx_frame_pin_oe_n, tx_frame_pin_o, tx_frame_pin_oe_n;
   logic tx_data_pin_o, tx_data_pin_oe_n, gen_bit_clock, gen_frame_pulse;
   logic tx_clock_enable, rx_clock_enable, tx_section_clear, rx_section_clear;
   int error_cnt = 0, checked = 0;
   // Two-way pins resolve to the device when its enable is low
   wire logic rx_clk_w = rx_clock_pin_oe_n ? ext_clk[1] : rx_clock_pin_o;
   wire logic tx_clk_w = tx_clock_pin_oe_n ? ext_clk[2] : tx_clock_pin_o;
   wire logic rx_fs_w = rx_frame_pin_oe_n ? ext_fs : rx_frame_pin_o;

   // Clock, 20 ns period, and a toggling transmit bit
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) tx_shift_bit <= ~tx_shift_bit;

   srg_top u_dut (
      .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .aux_clock_pin(ext_clk[0]), .rx_clock_pin_i(rx_clk_w), .tx_clock_pin_i(tx_clk_w),
      .rx_frame_pin_i(rx_fs_w), .low_speed_periph_clock(lsp_clk),
      .rx_clock_pin_o, .rx_clock_pin_oe_n, .tx_clock_pin_o, .tx_clock_pin_oe_n,
      .rx_frame_pin_o, .rx_frame_pin_oe_n, .tx_frame_pin_o, .tx_frame_pin_oe_n,
      .tx_shift_bit, .tx_data_pin_o, .tx_data_pin_oe_n, .debug_halt, .tx_word_done,
      .gen_bit_clock, .gen_frame_pulse, .tx_clock_enable, .rx_clock_enable,
      .tx_section_clear, .rx_section_clear
   );

   srg_codec_model u_codec (
      .core_clk, .rst_n, .clk_run, .fs_req, .pin_clk(ext_clk), .rx_fs(ext_fs), .lsp_clk
   );

   // ----------------------------------------
   // Bus and timing helpers
   // ----------------------------------------
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
   endtask

   // Settings change only while the generator is held in reset
   task automatic gen_cfg(input logic [15:0] c1, c2, pc, ctl);
      wr(3'h3, 16'h0000);
      wr(3'h0, c1);
      wr(3'h1, c2);
      wr(3'h2, pc);
      wr(3'h3, ctl);
      cyc(4);
   endtask

   function automatic logic sig(input int k);
      return k == 0 ? gen_bit_clock : gen_frame_pulse;
   endfunction

   task automatic wait_lvl(input int k, input logic v);
      int n;
      n = 0;
      while (sig(k) !== v && n < 400) begin
         cyc(1);
         n++;
      end
      if (n >= 400) begin
         error_cnt++;
         $display("MISMATCH wait %0d exp %0h got %0h", k, v, sig(k));
         give_verdict();
      end
   endtask

   // High and low lengths of one full cycle of a generated signal
   task automatic period(input int k, output int h, output int l);
      wait_lvl(k, 1'h0);
      wait_lvl(k, 1'h1);
      h = 0;
      l = 0;
      while (sig(k) === 1'h1 && h < 400) begin
         h++;
         cyc(1);
      end
      while (sig(k) === 1'h0 && l < 400) begin
         l++;
         cyc(1);
      end
      `CHK("period bound", 1'h1, h < 400 && l < 400)
      if (h >= 400 || l >= 400) give_verdict();
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      logic [15:0] d;
      logic p;
      for (int i = 0; i < 8; i++) begin
         p = lsp_clk;
         cyc(1);
         `CHK("slow clock", p, gen_bit_clock)
      end
      `CHK("frame idle", 1'h0, gen_frame_pulse)
      `CHK("held", 3'h7, {tx_section_clear, rx_section_clear, tx_data_pin_oe_n})
      rd(3'h0, d);
      `CHK("divide reset", 16'h0001, d)
      rd(3'h1, d);
      `CHK("source reset", 16'h2000, d)
      rd(3'h3, d);
      `CHK("port reset", 16'h0000, d)
      rd(3'h4, d);
      `CHK("post reset flag", 1'h1, d[6])
      wr(3'h5, 16'hFFFF);
      rd(3'h5, d);
      `CHK("unmapped", 16'h0000, d)
      $display("test reset done");
   endtask

   task automatic t_divide;
      int dv [5] = '{1, 2, 3, 4, 7};
      int h, l, eh;
      foreach (dv[i]) begin
         gen_cfg({8'h00, 8'(dv[i])}, 16'h2000, 16'h0000, 16'h0040);
         period(0, h, l);
         eh = (dv[i] % 2) ? (dv[i] + 1) / 2 : dv[i] / 2 + 1;
         `CHK("bit clock high", eh, h)
         `CHK("bit clock low", dv[i] + 1 - eh, l)
      end
      $display("test divide done");
   endtask

   task automatic t_frame;
      int h, l;
      logic txf, rxf, tgl, pc;
      // Width 1, period 7, divide 1; transmitter left in reset
      gen_cfg(16'h0101, 16'h2007, 16'h0F00, 16'h00C1);
      period(1, h, l);
      `CHK("frame width", 4, h)
      `CHK("frame gap", 12, l)
      txf = 1'h0;
      rxf = 1'h0;
      tgl = 1'h0;
      pc = tx_clock_pin_o;
      for (int i = 0; i < 40; i++) begin
         cyc(1);
         txf |= tx_frame_pin_o;
         rxf |= rx_frame_pin_o;
         tgl |= (tx_clock_pin_o !== pc);
         pc = tx_clock_pin_o;
      end
      `CHK("tx frame pin", 1'h0, txf)
      `CHK("rx frame pin", 1'h1, rxf)
      `CHK("tx clock pin", 2'h2, {tgl, tx_clock_pin_oe_n})
      `CHK("tx data", 1'h1, tx_data_pin_oe_n)
      `CHK("tx clear", 1'h1, tx_section_clear)
      wr(3'h3, 16'h0001);
      cyc(2);
      txf = 1'h0;
      for (int i = 0; i < 20; i++) begin
         cyc(1);
         txf |= gen_bit_clock | gen_frame_pulse;
      end
      `CHK("generator held", 1'h0, txf)
      $display("test frame done");
   endtask

   task automatic t_src;
      int since, tg, bad, p;
      logic pv, want, pin, pp, pb;
      clk_run <= 1'h1;
      for (int i = 0; i < 6; i++) begin
         p = i / 2;
         pv = 1'(i % 2);
         gen_cfg(16'h0001, 16'(pv && p == 0) << 14 | 16'(p == 2) << 13,
                 16'(p != 0) << 7 | 16'(pv && p == 2) << 1 | 16'(pv && p == 1), 16'h0040);
         want = (p == 1) ? pv : !pv;
         since = 99;
         tg = 0;
         bad = 0;
         pp = (p == 0) ? ext_clk[0] : (p == 1 ? rx_clk_w : tx_clk_w);
         pb = gen_bit_clock;
         for (int c = 0; c < 120; c++) begin
            cyc(1);
            pin = (p == 0) ? ext_clk[0] : (p == 1 ? rx_clk_w : tx_clk_w);
            if (pin !== pp && pin === want) since = 0;
            else since++;
            if (gen_bit_clock !== pb) begin
               tg++;
               if (tg > 1 && since > 4) bad++;
            end
            pp = pin;
            pb = gen_bit_clock;
         end
         `CHK("source runs", 1'h1, tg > 4)
         `CHK("edge choice", 0, bad)
      end
      $display("test source done");
   endtask

   task automatic t_resync;
      logic seen;
      int n;
      // Receive pin rising edge as source, divide 3, period 3 that must be ignored
      gen_cfg(16'h0003, 16'h8003, 16'h0081, 16'h00C0);
      seen = 1'h0;
      for (int i = 0; i < 60; i++) begin
         cyc(1);
         seen |= gen_frame_pulse;
      end
      `CHK("no free frame", 1'h0, seen)
      @(posedge core_clk);
      fs_req <= 1'h1;
      @(posedge core_clk);
      fs_req <= 1'h0;
      // Realigned divider starts the pulse on the first pin tick
      n = 0;
      while (gen_frame_pulse !== 1'h1 && n < 20) begin
         cyc(1);
         n++;
      end
      `CHK("realign delay", 1'h1, n < 20)
      wait_lvl(1, 1'h1);
      `CHK("bit clock realigned", 1'h1, gen_bit_clock)
      clk_run <= 1'h0;
      $display("test resync done");
   endtask

   task automatic t_emu;
      logic run;
      for (int m = 0; m < 3; m++) begin
         gen_cfg(16'h0001, 16'h2000, 16'h0000, 16'h00C3 | 16'(m) << 8);
         `CHK("running", 3'h6, {tx_clock_enable, rx_clock_enable, tx_data_pin_oe_n})
         `CHK("released", 2'h0, {tx_section_clear, rx_section_clear})
         debug_halt <= 1'h1;
         cyc(3);
         run = (m != 0);
         `CHK("halt", {run, run}, {tx_clock_enable, rx_clock_enable})
         if (m == 1) begin
            tx_word_done <= 1'h1;
            cyc(1);
            tx_word_done <= 1'h0;
            cyc(2);
            `CHK("soft stop", 2'h1, {tx_clock_enable, rx_clock_enable})
         end
         debug_halt <= 1'h0;
         cyc(3);
      end
      $display("test emulation done");
   endtask

   // Main sequence: reset for 5 cycles, then every scenario
   initial begin
      repeat (4) @(posedge core_clk);
      #1;
      `CHK("reset oe", 5'h1F, {rx_clock_pin_oe_n, tx_clock_pin_oe_n, rx_frame_pin_oe_n,
           tx_frame_pin_oe_n, tx_data_pin_oe_n})
      `CHK("reset clear", 2'h3, {tx_section_clear, rx_section_clear})
      @(posedge core_clk);
      rst_n <= 1'h1;
      t_reset();
      t_divide();
      t_frame();
      t_src();
      t_resync();
      t_emu();
      give_verdict();
   end
endmodule // tb_serial_port_sample_rate_gen_reset
`default_nettype wire
